// file: rtl/sab_map.svh
`ifndef SAB_MAP_SVH
`define SAB_MAP_SVH

// ==========================================
// Bus geometry
`define SAB_BYTE_W 8
`define SAB_SLOTS 3
`define SAB_FIFO_DEPTH 2

// ==========================================
// Values
`define SAB_IDLE_BYTE 8'h00
`define SAB_PHASE_W 2
`define SAB_PHASE_ZERO 2'h0
`define SAB_PHASE_ONE 2'h1

`endif

// file: rtl/sab_pkg.sv
`include "sab_map.svh"

package sab_pkg;
  // ==========================================
  // Link state
  typedef enum logic [1:0] {
    SAB_ST_FLOAT = 2'b00,
    SAB_ST_IDLE = 2'b01,
    SAB_ST_DRIVE = 2'b11
  } sab_state_e;

  typedef logic [`SAB_BYTE_W-1:0] sab_byte_t;
endpackage

// file: rtl/sab_add_port.sv
// Function
// R1: Drive each inserted byte on eight bits, bit 7 sent first.
// R2: Far party supplies a 19.44 MHz insert clock, one byte per cycle.
// R3: Own insert clock used only when timing select high; ignored when low.
// R4: Sample payload window and frame marker on falling insert clock edge.
// R5: Update parity and active-low slot indicator on rising insert clock edge.
// R6: Far party grounds insert clock, window and marker in drop timing.
// R7: Far party holds payload window high through VC-4 or each SPE period.
// R8: Far party gives one-clock C1 frame pulse at first C1 slot.
// R9: Frame marker also carries one or three one-clock J1 pulses.
// R10: With separate C1 input used, marker carries only J1; frame from that input.
// R11: Slot indicator low exactly in byte times the device places bytes.
// R12: Slot indicator high on no data, reset, drop clock loss or disabled. Code counts drop clock loss only in drop timing (select low).
// R13: Data outputs float on no data, reset, drop clock loss or disabled. Code counts drop clock loss only in drop timing (select low).
// R14: Odd parity over each placed byte, in both timing modes.
// R15: Parity output floats under the same four conditions as data.
// R16: In drop timing, derive clock, markers and window from drop bus.
// R17: OR separate C1 pulse with drop marker into one composite marker.
// R18: Data, parity and slot indicator change on the same rising edge.
`include "sab_map.svh"

module sab_add_port
  import sab_pkg::*;
#(
  parameter int DEPTH = `SAB_FIFO_DEPTH,
  parameter int SLOTS = `SAB_SLOTS
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [`SAB_BYTE_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic soft_reset,
  input wire logic insert_output_enable,
  input wire logic [SLOTS-1:0] slot_enable,
  input wire logic insert_timing_select,
  input wire logic drop_clock_loss,
  input wire logic insert_bus_clk,
  input wire logic insert_payload_window,
  input wire logic insert_frame_marker,
  input wire logic drop_byte_clock,
  input wire logic drop_payload_window,
  input wire logic drop_frame_marker,
  input wire logic drop_frame_pulse_alt,
  output logic [`SAB_BYTE_W-1:0] insert_data_out,
  output logic insert_data_oe_n,
  output logic insert_parity_out,
  output logic insert_parity_oe_n,
  output logic insert_slot_n
);

  localparam int AW = $clog2(DEPTH);

  // ==========================================
  // Parameter checks
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("DEPTH must be a power of two, at least 2");
    end
    if (SLOTS < 1 || SLOTS > 3) begin
      $error("SLOTS must be 1 to 3");
    end
  end

  localparam logic [AW:0] FULL_MASK = (AW+1)'(3) << (AW-1);
  localparam logic [`SAB_PHASE_W-1:0] LAST_PHASE = `SAB_PHASE_W'(SLOTS-1);

  // ==========================================
  // Link clock selection
  wire link_clk;
  // R3: select clock source
  // R16: drop clock in drop mode
  assign link_clk = insert_timing_select ? insert_bus_clk : drop_byte_clock;

  // ==========================================
  // Shared byte store
  sab_byte_t mem [DEPTH];

  // ==========================================
  // Write side on mclk
  // Gray pointers cross between domains, one bit changes per step
  logic [AW:0] wr_bin_r;
  logic [AW:0] wr_gray_r;
  logic [AW:0] rd_bin_r;
  logic [AW:0] rd_gray_r;
  logic [AW:0] rd_gray_m1_r;
  logic [AW:0] rd_gray_m2_r;
  logic in_ready_r;
  wire wr_go;
  wire [AW:0] wr_bin_nxt;
  wire [AW:0] wr_gray_nxt;
  wire full_nxt;

  // Byte taken only while the buffer has room
  assign wr_go = in_valid & in_ready_r;
  assign wr_bin_nxt = wr_go ? wr_bin_r + (AW+1)'(1) : wr_bin_r;
  assign wr_gray_nxt = wr_bin_nxt ^ (wr_bin_nxt >> 1);
  // Full when the top two gray bits differ from the synced read pointer
  assign full_nxt = wr_gray_nxt == (rd_gray_m2_r ^ FULL_MASK);

  always_ff @(posedge mclk) begin
    if (wr_go) begin
      mem[wr_bin_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_bin_r <= '0;
      wr_gray_r <= '0;
      rd_gray_m1_r <= '0;
      rd_gray_m2_r <= '0;
      in_ready_r <= 1'b0;
    end else begin
      wr_bin_r <= wr_bin_nxt;
      wr_gray_r <= wr_gray_nxt;
      rd_gray_m1_r <= rd_gray_r;
      rd_gray_m2_r <= rd_gray_m1_r;
      in_ready_r <= ~full_nxt;
    end
  end

  assign in_ready = in_ready_r;

  // ==========================================
  // Reset and control sync into link domain
  logic lrst_s1_r;
  logic lrst_s2_r;
  logic soft_s1_r;
  logic soft_s2_r;
  logic oe_s1_r;
  logic oe_s2_r;
  logic loss_s1_r;
  logic loss_s2_r;
  logic sel_s1_r;
  logic sel_s2_r;
  logic [SLOTS-1:0] mask_s1_r;
  logic [SLOTS-1:0] mask_s2_r;
  logic [AW:0] wr_gray_l1_r;
  logic [AW:0] wr_gray_l2_r;

  always_ff @(posedge link_clk) begin
    lrst_s1_r <= rst;
    lrst_s2_r <= lrst_s1_r;
    soft_s1_r <= soft_reset;
    soft_s2_r <= soft_s1_r;
    oe_s1_r <= insert_output_enable;
    oe_s2_r <= oe_s1_r;
    loss_s1_r <= drop_clock_loss;
    loss_s2_r <= loss_s1_r;
    sel_s1_r <= insert_timing_select;
    sel_s2_r <= sel_s1_r;
    mask_s1_r <= slot_enable;
    mask_s2_r <= mask_s1_r;
  end

  // ==========================================
  // Falling-edge timing capture
  logic ins_win_f_r;
  logic ins_mark_f_r;
  logic drp_win_f_r;
  logic drp_mark_f_r;
  logic alt_f_r;

  // R4: falling edge sampling
  always_ff @(negedge link_clk) begin
    ins_win_f_r <= insert_payload_window;
    ins_mark_f_r <= insert_frame_marker;
    drp_win_f_r <= drop_payload_window;
    drp_mark_f_r <= drop_frame_marker;
    alt_f_r <= drop_frame_pulse_alt;
  end

  wire win;
  wire mark;
  wire c1_seen;

  // R3: ignore insert inputs
  // R16: drop window and marker
  assign win = sel_s2_r ? ins_win_f_r : drp_win_f_r;
  // R17: composite marker
  // R10: frame from separate pulse
  assign mark = (sel_s2_r ? ins_mark_f_r : drp_mark_f_r) | alt_f_r;
  assign c1_seen = mark & ~win;

  // ==========================================
  // Frame lock
  logic framed_r;
  wire framed_cur;

  // R10: lock on frame pulse
  // R17: composite marker locks phase
  // Slot ownership is unknown until the first C1 arrives
  assign framed_cur = framed_r | c1_seen;

  always_ff @(posedge link_clk) begin
    if (lrst_s2_r) begin
      framed_r <= 1'b0;
    end else begin
      framed_r <= framed_cur;
    end
  end

  // ==========================================
  // Slot phase tracking
  logic [`SAB_PHASE_W-1:0] phase_r;
  wire [`SAB_PHASE_W-1:0] phase_cur;
  wire [`SAB_PHASE_W-1:0] phase_nxt;
  wire phase_hit;

  assign phase_cur = c1_seen ? `SAB_PHASE_ZERO : phase_r;
  assign phase_nxt = (phase_cur == LAST_PHASE) ? `SAB_PHASE_ZERO
                   : phase_cur + `SAB_PHASE_ONE;
  // Owned slot only once the frame position is known
  assign phase_hit = framed_cur & mask_s2_r[phase_cur];

  always_ff @(posedge link_clk) begin
    if (lrst_s2_r) begin
      phase_r <= `SAB_PHASE_ZERO;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // ==========================================
  // Read side on link clock
  wire empty;
  wire ctrl_float;
  wire loss_float;
  wire drive_ok;
  wire pop;
  wire [AW:0] rd_bin_nxt;
  sab_byte_t pop_byte;

  assign empty = rd_gray_r == wr_gray_l2_r;
  // R12: gating conditions
  // R13: float on loss or disable
  assign ctrl_float = ~oe_s2_r | soft_s2_r | lrst_s2_r;
  // R16: loss counts in drop timing
  assign loss_float = loss_s2_r & ~sel_s2_r;
  assign drive_ok = ~ctrl_float & ~loss_float;
  assign pop = drive_ok & win & phase_hit & ~empty;
  assign rd_bin_nxt = pop ? rd_bin_r + (AW+1)'(1) : rd_bin_r;
  assign pop_byte = mem[rd_bin_r[AW-1:0]];

  always_ff @(posedge link_clk) begin
    if (lrst_s2_r) begin
      rd_bin_r <= '0;
      rd_gray_r <= '0;
      wr_gray_l1_r <= '0;
      wr_gray_l2_r <= '0;
    end else begin
      rd_bin_r <= rd_bin_nxt;
      rd_gray_r <= rd_bin_nxt ^ (rd_bin_nxt >> 1);
      wr_gray_l1_r <= wr_gray_r;
      wr_gray_l2_r <= wr_gray_l1_r;
    end
  end

  // ==========================================
  // Link state
  sab_state_e state_r;
  sab_state_e state_nxt;

  always_comb begin
    case (state_r)
      SAB_ST_FLOAT,
      SAB_ST_IDLE,
      SAB_ST_DRIVE: begin
        if (!drive_ok) begin
          state_nxt = SAB_ST_FLOAT;
        end else if (pop) begin
          state_nxt = SAB_ST_DRIVE;
        end else begin
          state_nxt = SAB_ST_IDLE;
        end
      end
      default: begin
        state_nxt = SAB_ST_FLOAT;
      end
    endcase
  end

  always_ff @(posedge link_clk) begin
    if (lrst_s2_r) begin
      state_r <= SAB_ST_FLOAT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // Bus outputs
  logic [`SAB_BYTE_W-1:0] data_r;
  logic data_oe_n_r;
  logic par_r;
  logic par_oe_n_r;
  logic slot_n_r;
  wire [`SAB_BYTE_W-1:0] data_nxt;
  wire par_nxt;
  wire place_n_nxt;

  // R11: slot placed only on a pop
  // Enables and slot indicator share one decision, so they never skew
  assign place_n_nxt = ~pop;

  // R1: byte on eight lanes, bit 7 first
  assign data_nxt = pop ? pop_byte : `SAB_IDLE_BYTE;
  // R14: odd parity
  assign par_nxt = pop ? ~^pop_byte : 1'b0;

  // R5: rising edge update
  // R18: aligned outputs
  always_ff @(posedge link_clk) begin
    if (lrst_s2_r) begin
      data_r <= `SAB_IDLE_BYTE;
      data_oe_n_r <= 1'b1;
      par_r <= 1'b0;
      par_oe_n_r <= 1'b1;
      slot_n_r <= 1'b1;
    end else begin
      data_r <= data_nxt;
      // R13: float when not placing
      data_oe_n_r <= place_n_nxt;
      par_r <= par_nxt;
      // R15: parity floats with data
      par_oe_n_r <= place_n_nxt;
      // R11: low only in placed slots
      // R12: high otherwise
      slot_n_r <= place_n_nxt;
    end
  end

  assign insert_data_out = data_r;
  assign insert_data_oe_n = data_oe_n_r;
  assign insert_parity_out = par_r;
  assign insert_parity_oe_n = par_oe_n_r;
  assign insert_slot_n = slot_n_r;

endmodule

// file: tb/sab_add_port_chk.sv
module sab_add_port_chk
  import sab_pkg::*;
#(
  parameter int SLOTS = 3
) (
  input wire logic rst,
  input wire logic insert_bus_clk,
  input wire logic soft_reset,
  input wire logic insert_output_enable,
  input wire logic [SLOTS-1:0] slot_enable,
  input wire logic insert_payload_window,
  input wire sab_byte_t insert_data_out,
  input wire logic insert_data_oe_n,
  input wire logic insert_parity_out,
  input wire logic insert_parity_oe_n,
  input wire logic insert_slot_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Checks
  default clocking @(posedge insert_bus_clk); endclocking
  default disable iff (rst);
  sequence gate_off;
    !insert_output_enable [*4];
  endsequence
  sequence soft_on;
    soft_reset [*4];
  endsequence
  slot_oe_a: assert property (insert_slot_n == insert_data_oe_n)
    else $error("slot indicator and data enable differ");
  par_oe_a: assert property (insert_parity_oe_n == insert_data_oe_n)
    else $error("parity enable and data enable differ");
  odd_par_a: assert property (!insert_data_oe_n |-> insert_parity_out == ~^insert_data_out)
    else $error("parity not odd");
  gate_float_a: assert property (gate_off |=> insert_slot_n && insert_data_oe_n)
    else $error("bus driven while disabled");
  soft_float_a: assert property (soft_on |=> insert_data_oe_n && insert_parity_oe_n)
    else $error("bus driven during soft reset");
  window_drive_a: assert property (!insert_slot_n |-> $past(insert_payload_window))
    else $error("bus driven outside payload window");
  unowned_a: assert property ((slot_enable == '0) [*4] |=> insert_slot_n)
    else $error("bus driven with no owned slot");
  idle_byte_a: assert property (insert_data_oe_n |-> insert_data_out == 8'h00)
    else $error("data not idle while floating");
endmodule

bind sab_add_port sab_add_port_chk #(.SLOTS(SLOTS)) chk (
  .rst(rst), .insert_bus_clk(insert_bus_clk), .soft_reset(soft_reset),
  .insert_output_enable(insert_output_enable), .slot_enable(slot_enable),
  .insert_payload_window(insert_payload_window), .insert_data_out(insert_data_out),
  .insert_data_oe_n(insert_data_oe_n), .insert_parity_out(insert_parity_out),
  .insert_parity_oe_n(insert_parity_oe_n), .insert_slot_n(insert_slot_n)
);

// file: tb/sab_far_timing.sv
module sab_far_timing (
  output logic clk,
  output logic window,
  output logic marker
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Bus timing
  int cnt = 0;
  int pc = 0;
  initial begin
    clk = 1'b0;
    #1.7;
    forever #3 clk = ~clk;
  end
  always @(posedge clk) begin
    pc <= cnt;
    cnt <= #1 (cnt + 1) % 12;
  end
  assign window = (cnt >= 3);
  assign marker = (cnt == 0) || (cnt == 3);
endmodule

// file: tb/test_sab_add_port.sv
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end

module test_sab_add_port
  import sab_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================
  // Signals
  logic mclk = 1'b0;
  logic rst = 1'b1;
  sab_byte_t in_data = 8'h00;
  logic in_valid = 1'b0;
  logic soft_reset = 1'b0;
  logic insert_output_enable = 1'b1;
  logic drop_clock_loss = 1'b0;
  logic [2:0] slot_enable = 3'h0;
  logic in_ready, insert_bus_clk, insert_payload_window, insert_frame_marker;
  sab_byte_t insert_data_out;
  logic insert_data_oe_n, insert_parity_out, insert_parity_oe_n, insert_slot_n;
  int failures = 0;
  int samples_checked = 0;
  sab_byte_t sent[$];
  sab_byte_t got[$];

  always #4 mclk = ~mclk;
  sab_far_timing far (.clk(insert_bus_clk), .window(insert_payload_window),
    .marker(insert_frame_marker));
  // drop clock, window and marker grounded, separate pulse unused
  sab_add_port dut (.mclk(mclk), .rst(rst), .in_data(in_data), .in_valid(in_valid),
    .in_ready(in_ready), .soft_reset(soft_reset), .insert_output_enable(insert_output_enable),
    .slot_enable(slot_enable), .insert_timing_select(1'b1), .drop_clock_loss(drop_clock_loss),
    .insert_bus_clk(insert_bus_clk), .insert_payload_window(insert_payload_window),
    .insert_frame_marker(insert_frame_marker), .drop_byte_clock(1'b0),
    .drop_payload_window(1'b0), .drop_frame_marker(1'b0), .drop_frame_pulse_alt(1'b0),
    .insert_data_out(insert_data_out), .insert_data_oe_n(insert_data_oe_n),
    .insert_parity_out(insert_parity_out), .insert_parity_oe_n(insert_parity_oe_n),
    .insert_slot_n(insert_slot_n));

  // ==========================================
  // Bus monitor
  always @(negedge insert_bus_clk) begin
    if (insert_slot_n === 1'b0) begin
      `CHK(insert_parity_out, ~^insert_data_out)
      `CHK({slot_enable[far.pc % 3], far.pc >= 3}, 2'b11)
      got.push_back(insert_data_out);
    end
  end

  // ==========================================
  // Tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic put(input sab_byte_t b);
    in_data = b;
    in_valid = 1'b1;
    sent.push_back(b);
    repeat (300) if (in_ready !== 1'b1) @(negedge mclk);
    cyc(1);
  endtask
  task automatic settle(input int n);
    repeat (3000) if (got.size() < n) @(posedge mclk);
    cyc(4);
    `CHK(got.size(), n)
    for (int i = 0; i < n; i++) `CHK(got[i], sent[i])
    got.delete();
    sent.delete();
  endtask
  task automatic t_flow();
    slot_enable = 3'h5;
    drop_clock_loss = 1'b1;
    for (int i = 0; i < 8; i++) put(8'hA0 + 8'(i * 7));
    in_valid = 1'b0;
    settle(8);
    drop_clock_loss = 1'b0;
  endtask
  task automatic t_gate();
    for (int i = 0; i < 3; i++) begin
      insert_output_enable = (i != 0);
      soft_reset = (i == 1);
      slot_enable = (i == 2) ? 3'h0 : 3'h2;
      cyc(10);
      put(8'h3C + 8'(i));
      in_valid = 1'b0;
      cyc(40);
      `CHK(got.size(), 0)
      insert_output_enable = 1'b1;
      soft_reset = 1'b0;
      slot_enable = 3'h2;
      settle(1);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // Sequence
  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(2);
    t_flow();
    t_gate();
    close_out();
  end
  // Tests need a few microseconds
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule
